/* File: hw/lsr_pkg.sv */
// Constants and types shared by the light sensor register bank.
// Assumes a 250 MHz reference clock and a two-wire serial link on its own clock.
package lsr_pkg;
    // Register pointer values
    localparam logic [7:0] REG_RESULT = 8'h00;
    localparam logic [7:0] REG_CFG    = 8'h01;
    localparam logic [7:0] REG_LOWER  = 8'h02;
    localparam logic [7:0] REG_UPPER  = 8'h03;
    localparam logic [7:0] REG_MAKER  = 8'h7e;
    localparam logic [7:0] REG_PART   = 8'h7f;

    // Word layout shared by result and thresholds
    localparam int EXP_LSB  = 12;
    localparam int EXP_W    = 4;
    localparam int MANT_W   = 12;
    localparam logic [11:0] MANT_FULL = 12'hfff;
    localparam logic [3:0]  EXP_MAX   = 4'hb;
    localparam int EXP_TOP  = 11;

    // Control word layout
    localparam int RANGE_LSB = 12;
    localparam int RANGE_W   = 4;
    localparam int LEN_BIT   = 11;
    localparam int MODE_LSB  = 9;
    localparam int MODE_W    = 2;
    localparam int OVF_BIT   = 8;
    localparam int DONE_BIT  = 7;
    localparam int ABOVE_BIT = 6;
    localparam int BELOW_BIT = 5;
    localparam int LATCH_BIT = 4;
    localparam int POL_BIT   = 3;
    localparam int MASK_BIT  = 2;
    localparam int FC_LSB    = 0;
    localparam int FC_W      = 2;

    localparam logic [15:0] CFG_RESET    = 16'hc810;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] LOWER_RESET  = 16'h0000;
    localparam logic [15:0] UPPER_RESET  = 16'hffff;
    localparam logic [3:0]  RANGE_AUTO   = 4'hc;
    localparam logic [1:0]  MODE_OFF     = 2'h0;
    localparam logic [1:0]  MODE_SINGLE  = 2'h1;

    // Serial framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] BYTE_ADDR = 2'h0;
    localparam logic [1:0] BYTE_PTR  = 2'h1;
    localparam logic [1:0] BYTE_HI   = 2'h2;
    localparam logic [1:0] BYTE_LO   = 2'h3;

    // Integration times
    localparam int unsigned CONV_SHORT_MS = 100;
    localparam int unsigned CONV_LONG_MS  = 800;
    localparam int unsigned REF_CLK_KHZ   = 250_000;
    localparam int TIMER_W = 28;
    typedef logic [TIMER_W-1:0] lsr_count_t;

    typedef enum logic [2:0] {
        LS_IDLE,
        LS_RX,
        LS_ACK_OUT,
        LS_TX,
        LS_ACK_IN
    } lsr_link_state_t;
endpackage

/* File: hw/lsr_link_capture.sv */
// Link-clock side of the serial port: samples data on each rising link clock.
// Assumes rst is held while the link clock is idle; data stays put one link period.
module lsr_link_capture (
    input  wire logic scl_clk,
    input  wire logic rst,
    input  wire logic sda_in,
    output logic      bit_value,
    output logic      bit_toggle
);
    // Reset asserted from the reference side, so it acts without a link edge
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            bit_value  <= 1'b0;
            bit_toggle <= 1'b0;
        end else begin
            bit_value  <= sda_in;
            bit_toggle <= ~bit_toggle;
        end
    end
endmodule

/* File: hw/lsr_regbank.sv */
// Register bank of an ambient light sensor, reached over a two-wire serial link.
// Assumes an open-drain data line resolved outside and a same-clock light count input.
//
// How it works
// - Every register is a 16-bit word reachable over the serial link.
// - Result 00h, control 01h, limits 02h/03h, identity 7Eh and 7Fh.
// - Result is read-only: exponent in 15:12, mantissa in 11:0.
// - Mantissa is unsigned binary from zero to the range's full scale.
// - One mantissa step is 0.01 lux times two to the exponent, codes 0-11.
// - Result resets to zero exponent and zero mantissa.
// - Result always holds the most recently completed conversion.
// - Exponent reads zero when mask is set and range is manual.
// - A control write abandons a running conversion at once.
// - After that abort a new conversion starts if the mode asks for one.
// - Control word resets to C810h.
// - Control layout fixed; bits 8 to 5 are read-only.
// - Range field selects full scale with the exponent's code mapping.
// - Range 1100b picks the scale automatically and reports it as exponent.
// - Power-up range is 1100b, automatic.
// - Mode 00 shutdown, 01 single conversion, 10/11 continuous.
// - Conversion-ready flag clears right after each control word read unless a conversion ends in that same cycle.
// - Register pointer changes only when a write supplies a pointer byte.
// - Words travel high byte first, then low byte.
module lsr_regbank #(
    parameter logic [6:0]  DEV_ADDR       = 7'h44,
    parameter logic [15:0] MAKER_ID       = 16'h1234, // Arbitrary value
    parameter logic [15:0] PART_ID        = 16'h5678, // Arbitrary value
    parameter int          RAW_W          = 24,
    parameter int unsigned CONV_SHORT_CYC = lsr_pkg::CONV_SHORT_MS * lsr_pkg::REF_CLK_KHZ,
    parameter int unsigned CONV_LONG_CYC  = lsr_pkg::CONV_LONG_MS * lsr_pkg::REF_CLK_KHZ
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             scl_clk,
    input  wire logic             sda_in,
    output logic                  sda_out,
    output logic                  sda_oe,
    input  wire logic [RAW_W-1:0] light_level,
    output logic                  integrating
);
    localparam logic [RAW_W-1:0] FULL_MANT = RAW_W'(lsr_pkg::MANT_FULL);
    localparam lsr_pkg::lsr_count_t SHORT_LAST = lsr_pkg::lsr_count_t'(CONV_SHORT_CYC - 1);
    localparam lsr_pkg::lsr_count_t LONG_LAST  = lsr_pkg::lsr_count_t'(CONV_LONG_CYC - 1);

    typedef struct packed {
        logic [2:0]               scl_sync;
        logic [2:0]               sda_sync;
        logic [2:0]               tgl_sync;
        lsr_pkg::lsr_link_state_t ls;
        logic [3:0]               bit_cnt;
        logic [1:0]               byte_idx;
        logic [7:0]               shift;
        logic [7:0]               hi_byte;
        logic [15:0]              tx_word;
        logic                     is_read;
        logic                     master_nack;
        logic                     sda_drive;
        logic [7:0]               ptr;
        logic [3:0]               range_sel;
        logic                     integration_length;
        logic [1:0]               conv_mode;
        logic                     overrange_flag;
        logic                     conversion_done_flag;
        logic                     latch_en;
        logic                     alert_polarity;
        logic                     scale_mask;
        logic [1:0]               fault_count;
        logic [15:0]              light_result;
        logic [15:0]              lower_threshold;
        logic [15:0]              upper_threshold;
        logic                     busy;
        lsr_pkg::lsr_count_t      timer;
    } lsr_state_t;

    lsr_state_t st;
    lsr_state_t next_st;

    logic       link_bit;
    logic       link_tgl;
    logic       rise_evt;
    logic       fall_evt;
    logic       start_evt;
    logic       stop_evt;
    logic       byte_end;
    logic       ptr_load;
    logic       wr_commit;
    logic       cfg_wr;
    logic       cfg_rd;
    logic       conv_end;
    logic       auto_range;
    logic [15:0] cfg_word;
    logic [15:0] rd_word;
    logic [15:0] wr_word;
    logic [16:0] scaled;

    lsr_link_capture u_capture (
        .scl_clk    (scl_clk),
        .rst        (rst),
        .sda_in     (sda_in),
        .bit_value  (link_bit),
        .bit_toggle (link_tgl)
    );

    // Returns {overrange, exponent, mantissa} for a linear light count
    function automatic logic [16:0] lsr_scale(input logic [RAW_W-1:0] raw, input logic [3:0] rn);
        logic [RAW_W-1:0] sh;
        logic [3:0]       e;
        logic             ovf;
        sh  = '0;
        e   = rn;
        ovf = 1'b0;
        if (rn == lsr_pkg::RANGE_AUTO) begin
            // Smallest exponent whose full scale holds the count
            e   = lsr_pkg::EXP_MAX;
            ovf = 1'b1;
            for (int i = lsr_pkg::EXP_TOP; i >= 0; i--) begin
                if ((raw >> i) <= FULL_MANT) begin
                    e   = 4'(i);
                    ovf = 1'b0;
                end
            end
        end
        sh = raw >> e;
        if (sh > FULL_MANT) begin
            sh  = FULL_MANT;
            ovf = 1'b1;
        end
        return {ovf, e, sh[lsr_pkg::MANT_W-1:0]};
    endfunction

    // Edges come from the second synchroniser stage against a third
    assign rise_evt   = st.tgl_sync[1] != st.tgl_sync[2];
    assign start_evt  = st.scl_sync[1] && st.scl_sync[2] && st.sda_sync[2] && !st.sda_sync[1];
    assign stop_evt   = st.scl_sync[1] && st.scl_sync[2] && !st.sda_sync[2] && st.sda_sync[1];
    assign fall_evt   = st.scl_sync[2] && !st.scl_sync[1] && !start_evt && !stop_evt;
    assign byte_end   = fall_evt && st.ls == lsr_pkg::LS_RX && st.bit_cnt == lsr_pkg::BYTE_BITS;
    assign ptr_load   = byte_end && st.byte_idx == lsr_pkg::BYTE_PTR;
    assign wr_commit  = byte_end && st.byte_idx == lsr_pkg::BYTE_LO;
    assign cfg_wr     = wr_commit && st.ptr == lsr_pkg::REG_CFG;
    assign cfg_rd     = byte_end && st.byte_idx == lsr_pkg::BYTE_ADDR
                        && st.shift == {DEV_ADDR, 1'b1} && st.ptr == lsr_pkg::REG_CFG;
    assign conv_end   = st.busy && !cfg_wr
                        && st.timer == (st.integration_length ? LONG_LAST : SHORT_LAST);
    assign auto_range = st.range_sel == lsr_pkg::RANGE_AUTO;
    assign wr_word    = {st.hi_byte, st.shift};
    assign scaled     = lsr_scale(light_level, st.range_sel);

    always_comb begin
        cfg_word = '0;
        cfg_word[lsr_pkg::RANGE_LSB +: lsr_pkg::RANGE_W] = st.range_sel;
        cfg_word[lsr_pkg::LEN_BIT]                       = st.integration_length;
        cfg_word[lsr_pkg::MODE_LSB +: lsr_pkg::MODE_W]   = st.conv_mode;
        cfg_word[lsr_pkg::OVF_BIT]                       = st.overrange_flag;
        cfg_word[lsr_pkg::DONE_BIT]                      = st.conversion_done_flag;
        cfg_word[lsr_pkg::LATCH_BIT]                     = st.latch_en;
        cfg_word[lsr_pkg::POL_BIT]                       = st.alert_polarity;
        cfg_word[lsr_pkg::MASK_BIT]                      = st.scale_mask;
        cfg_word[lsr_pkg::FC_LSB +: lsr_pkg::FC_W]       = st.fault_count;
    end

    // Limit comparison is not part of this bank, so both limit flags read zero
    always_comb begin
        unique case (st.ptr)
            lsr_pkg::REG_RESULT: begin
                rd_word = st.light_result;
                if (st.scale_mask && st.range_sel < lsr_pkg::RANGE_AUTO) begin
                    rd_word[lsr_pkg::EXP_LSB +: lsr_pkg::EXP_W] = '0;
                end
            end
            lsr_pkg::REG_CFG:   rd_word = cfg_word;
            lsr_pkg::REG_LOWER: rd_word = st.lower_threshold;
            lsr_pkg::REG_UPPER: rd_word = st.upper_threshold;
            lsr_pkg::REG_MAKER: rd_word = MAKER_ID;
            lsr_pkg::REG_PART:  rd_word = PART_ID;
            default:            rd_word = '0;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.scl_sync = {st.scl_sync[1:0], scl_clk};
        next_st.sda_sync = {st.sda_sync[1:0], sda_in};
        next_st.tgl_sync = {st.tgl_sync[1:0], link_tgl};

        // Link framing
        if (start_evt) begin
            next_st.ls        = lsr_pkg::LS_RX;
            next_st.bit_cnt   = '0;
            next_st.byte_idx  = lsr_pkg::BYTE_ADDR;
            next_st.sda_drive = 1'b0;
        end else if (stop_evt) begin
            next_st.ls        = lsr_pkg::LS_IDLE;
            next_st.sda_drive = 1'b0;
        end else if (rise_evt) begin
            if (st.ls == lsr_pkg::LS_RX) begin
                next_st.shift   = {st.shift[6:0], link_bit};
                next_st.bit_cnt = st.bit_cnt + 4'h1;
            end else if (st.ls == lsr_pkg::LS_ACK_IN) begin
                next_st.master_nack = link_bit;
            end
        end else if (fall_evt) begin
            unique case (st.ls)
                lsr_pkg::LS_RX: begin
                    if (byte_end) begin
                        next_st.bit_cnt   = '0;
                        next_st.ls        = lsr_pkg::LS_ACK_OUT;
                        next_st.sda_drive = 1'b1;
                        unique case (st.byte_idx)
                            lsr_pkg::BYTE_ADDR: begin
                                next_st.is_read  = st.shift[0];
                                next_st.byte_idx = lsr_pkg::BYTE_PTR;
                                next_st.tx_word  = rd_word;
                                if (st.shift[7:1] != DEV_ADDR) begin
                                    next_st.ls        = lsr_pkg::LS_IDLE;
                                    next_st.sda_drive = 1'b0;
                                end
                            end
                            lsr_pkg::BYTE_PTR: begin
                                next_st.ptr      = st.shift;
                                next_st.byte_idx = lsr_pkg::BYTE_HI;
                            end
                            lsr_pkg::BYTE_HI: begin
                                next_st.hi_byte  = st.shift;
                                next_st.byte_idx = lsr_pkg::BYTE_LO;
                            end
                            lsr_pkg::BYTE_LO: begin
                                // Further bytes start another word for the same pointer
                                next_st.byte_idx = lsr_pkg::BYTE_HI;
                            end
                        endcase
                    end
                end
                lsr_pkg::LS_ACK_OUT, lsr_pkg::LS_ACK_IN: begin
                    next_st.sda_drive = 1'b0;
                    next_st.ls        = lsr_pkg::LS_RX;
                    if (st.ls == lsr_pkg::LS_ACK_IN && st.master_nack) begin
                        next_st.ls = lsr_pkg::LS_IDLE;
                    end else if (st.is_read) begin
                        // High byte leaves first, word rotates for repeated reads
                        next_st.ls        = lsr_pkg::LS_TX;
                        next_st.sda_drive = !st.tx_word[15];
                        next_st.tx_word   = {st.tx_word[14:0], st.tx_word[15]};
                        next_st.bit_cnt   = 4'h1;
                    end
                end
                lsr_pkg::LS_TX: begin
                    if (st.bit_cnt == lsr_pkg::BYTE_BITS) begin
                        next_st.ls          = lsr_pkg::LS_ACK_IN;
                        next_st.sda_drive   = 1'b0;
                        next_st.master_nack = 1'b0;
                    end else begin
                        next_st.sda_drive = !st.tx_word[15];
                        next_st.tx_word   = {st.tx_word[14:0], st.tx_word[15]};
                        next_st.bit_cnt   = st.bit_cnt + 4'h1;
                    end
                end
                lsr_pkg::LS_IDLE: begin
                    next_st.sda_drive = 1'b0;
                end
            endcase
        end

        // Register writes; result and identity pointers fall through untouched
        if (wr_commit) begin
            unique case (st.ptr)
                lsr_pkg::REG_CFG: begin
                    next_st.range_sel          = wr_word[lsr_pkg::RANGE_LSB +: lsr_pkg::RANGE_W];
                    next_st.integration_length = wr_word[lsr_pkg::LEN_BIT];
                    next_st.conv_mode          = wr_word[lsr_pkg::MODE_LSB +: lsr_pkg::MODE_W];
                    next_st.latch_en           = wr_word[lsr_pkg::LATCH_BIT];
                    next_st.alert_polarity     = wr_word[lsr_pkg::POL_BIT];
                    next_st.scale_mask         = wr_word[lsr_pkg::MASK_BIT];
                    next_st.fault_count        = wr_word[lsr_pkg::FC_LSB +: lsr_pkg::FC_W];
                    // Abort any running conversion, restart if the new mode converts
                    next_st.timer = '0;
                    next_st.busy  = wr_word[lsr_pkg::MODE_LSB +: lsr_pkg::MODE_W] != lsr_pkg::MODE_OFF;
                end
                lsr_pkg::REG_LOWER: next_st.lower_threshold = wr_word;
                lsr_pkg::REG_UPPER: next_st.upper_threshold = wr_word;
                default: ;
            endcase
        end

        // Conversion sequencing; the ready set wins over a same-cycle read clear
        if (cfg_rd) begin
            next_st.conversion_done_flag = 1'b0;
        end
        if (st.busy && !cfg_wr) begin
            next_st.timer = st.timer + lsr_pkg::lsr_count_t'(1);
        end
        if (conv_end) begin
            next_st.light_result         = scaled[15:0];
            next_st.overrange_flag       = scaled[16];
            next_st.conversion_done_flag = 1'b1;
            next_st.timer                = '0;
            if (st.conv_mode == lsr_pkg::MODE_SINGLE) begin
                next_st.conv_mode = lsr_pkg::MODE_OFF;
                next_st.busy      = 1'b0;
            end
        end

        if (rst) begin
            next_st                      = '0;
            next_st.ls                   = lsr_pkg::LS_IDLE;
            next_st.ptr                  = lsr_pkg::REG_RESULT;
            next_st.light_result         = lsr_pkg::RESULT_RESET;
            next_st.lower_threshold      = lsr_pkg::LOWER_RESET;
            next_st.upper_threshold      = lsr_pkg::UPPER_RESET;
            next_st.range_sel            = lsr_pkg::CFG_RESET[lsr_pkg::RANGE_LSB +: lsr_pkg::RANGE_W];
            next_st.integration_length   = lsr_pkg::CFG_RESET[lsr_pkg::LEN_BIT];
            next_st.conv_mode            = lsr_pkg::CFG_RESET[lsr_pkg::MODE_LSB +: lsr_pkg::MODE_W];
            next_st.overrange_flag       = lsr_pkg::CFG_RESET[lsr_pkg::OVF_BIT];
            next_st.conversion_done_flag = lsr_pkg::CFG_RESET[lsr_pkg::DONE_BIT];
            next_st.latch_en             = lsr_pkg::CFG_RESET[lsr_pkg::LATCH_BIT];
            next_st.alert_polarity       = lsr_pkg::CFG_RESET[lsr_pkg::POL_BIT];
            next_st.scale_mask           = lsr_pkg::CFG_RESET[lsr_pkg::MASK_BIT];
            next_st.fault_count          = lsr_pkg::CFG_RESET[lsr_pkg::FC_LSB +: lsr_pkg::FC_W];
        end
    end

    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end

    // Open drain: only ever pulls low
    assign sda_out     = 1'b0;
    assign sda_oe      = st.sda_drive;
    assign integrating = st.busy;

    default clocking lsr_cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_cfg_reset_val: assert property ($past(rst) |-> cfg_word == lsr_pkg::CFG_RESET)
        else $error("control word not at reset value after reset");
    a_result_holds: assert property (!$stable(st.light_result) |-> $past(conv_end))
        else $error("result changed without a completed conversion");
    a_mask_zero_exp: assert property ((st.ptr == lsr_pkg::REG_RESULT && st.scale_mask
            && st.range_sel < lsr_pkg::RANGE_AUTO)
            |-> rd_word == {4'h0, st.light_result[lsr_pkg::MANT_W-1:0]})
        else $error("masked exponent not zero");
    a_write_abort: assert property (cfg_wr |=> st.timer == '0
            && st.busy == (st.conv_mode != lsr_pkg::MODE_OFF))
        else $error("control write did not abort or restart conversion");
    a_ready_clear: assert property ((cfg_rd && !conv_end) |=> !st.conversion_done_flag)
        else $error("ready flag not cleared after control read");
    a_ptr_hold: assert property (!$stable(st.ptr) |-> $past(ptr_load))
        else $error("pointer changed without a pointer byte");
    a_single_stop: assert property ((conv_end && st.conv_mode == lsr_pkg::MODE_SINGLE)
            |=> st.conv_mode == lsr_pkg::MODE_OFF && !st.busy ##1 !st.busy)
        else $error("single conversion did not return to shutdown");
    a_auto_exp: assert property ((conv_end && auto_range) |=> st.light_result[15:12] <= lsr_pkg::EXP_MAX)
        else $error("automatic range chose a reserved exponent");
    a_ro_bits: assert property ((cfg_wr && !conv_end) |=> $stable(st.overrange_flag))
        else $error("write reached a read-only control bit");
endmodule

/* File: sim/lsr_host_model.sv */
// Host side of the sensor's two-wire link: makes the link clock and pulls data low.
// Assumes the bench resolves the wired-AND data line with a pull-up and feeds it back.
module lsr_host_model (
    output logic      scl_clk,
    output logic      host_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] DEV = 7'h44;
    int nak_seen = 0;
    initial begin
        scl_clk  = 1'b1;
        host_low = 1'b0;
    end
    // Data moves late in the low phase, after the device has let go of its bit
    task automatic put(input logic b);
        #24 host_low = !b;
        #8 scl_clk = 1'b1;
        #32 scl_clk = 1'b0;
    endtask
    task automatic get(output logic b);
        #24 host_low = 1'b0;
        #8 scl_clk = 1'b1;
        #16 b = sda;
        #16 scl_clk = 1'b0;
    endtask
    task automatic send(input logic [7:0] d);
        logic ack;
        for (int i = 7; i >= 0; i--) put(d[i]);
        get(ack);
        if (ack !== 1'b0) nak_seen++;
    endtask
    task automatic start(input logic rd);
        #16 host_low = 1'b1;
        #32 scl_clk = 1'b0;
        send({DEV, rd});
    endtask
    task automatic stop();
        #24 host_low = 1'b1;
        #8 scl_clk = 1'b1;
        #32 host_low = 1'b0;
        #32;
    endtask
    // Callers keep range codes below 1101b
    task automatic write_word(input logic [7:0] ptr, input logic [15:0] w);
        start(1'b0);
        send(ptr);
        send(w[15:8]);
        send(w[7:0]);
        stop();
    endtask
    task automatic read_cur(output logic [15:0] w);
        logic b;
        start(1'b1);
        for (int i = 15; i >= 0; i--) begin
            get(b);
            w[i] = b;
            if (i == 8) put(1'b0);
        end
        put(1'b1);
        stop();
    endtask
    task automatic read_word(input logic [7:0] ptr, output logic [15:0] w);
        start(1'b0);
        send(ptr);
        stop();
        read_cur(w);
    endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the light sensor register bank over its serial link.
// Assumes conversion lengths cut to 20 and 40 reference cycles.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [23:0] light_level = 24'h00_0000;
    logic        scl_clk;
    logic        host_low;
    logic        sda_oe;
    logic        sda_out;
    logic        integrating;
    logic [15:0] rd;
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    wire logic   sda_line = !host_low && (sda_oe ? sda_out : 1'b1);
    lsr_regbank #(.CONV_SHORT_CYC(20), .CONV_LONG_CYC(40)) u_lsr_regbank (.ref_clk(ref_clk), .rst(rst),
        .scl_clk(scl_clk), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .light_level(light_level),
        .integrating(integrating));
    lsr_host_model u_lsr_host_model (.scl_clk(scl_clk), .host_low(host_low), .sda(sda_line));
    initial forever #2 ref_clk = !ref_clk;
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("Checked %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] ptr, input logic [15:0] exp);
        u_lsr_host_model.read_word(ptr, rd);
        check(name, rd, exp);
    endtask
    task automatic convert(input logic [15:0] cfg, input logic [23:0] lvl);
        @(negedge ref_clk) light_level = lvl;
        u_lsr_host_model.write_word(8'h01, cfg);
        for (int i = 0; i < 200 && integrating !== 1'b0; i++) @(negedge ref_clk);
    endtask
    // Whole run needs about 21500 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            results();
        end
    end
    initial begin
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        rd_chk("cfg_reset", 8'h01, 16'hc810);
        rd_chk("result_reset", 8'h00, 16'h0000);
        rd_chk("lower_reset", 8'h02, 16'h0000);
        rd_chk("upper_reset", 8'h03, 16'hffff);
        rd_chk("maker", 8'h7e, 16'h1234);
        rd_chk("part", 8'h7f, 16'h5678);
        rd_chk("unmapped", 8'h10, 16'h0000);
        $display("Test reset_values done");
        u_lsr_host_model.write_word(8'h02, 16'habcd);
        u_lsr_host_model.read_cur(rd);
        check("ptr_kept", rd, 16'habcd);
        u_lsr_host_model.write_word(8'h00, 16'hffff);
        u_lsr_host_model.write_word(8'h7f, 16'h0000);
        u_lsr_host_model.write_word(8'h01, 16'h01ff);
        rd_chk("result_ro", 8'h00, 16'h0000);
        rd_chk("part_ro", 8'h7f, 16'h5678);
        rd_chk("cfg_ro_bits", 8'h01, 16'h001f);
        $display("Test write_access done");
        convert(16'hc204, 24'h00_3456);
        rd_chk("auto_result", 8'h00, 16'h2d15);
        rd_chk("single_done", 8'h01, 16'hc084);
        u_lsr_host_model.read_cur(rd);
        check("ready_clear", rd, 16'hc004);
        convert(16'h3204, 24'h00_3456);
        rd_chk("masked_exp", 8'h00, 16'h068a);
        convert(16'h0200, 24'hff_ffff);
        rd_chk("manual_clamp", 8'h00, 16'h0fff);
        rd_chk("overflow", 8'h01, 16'h0180);
        $display("Test conversions done");
        convert(16'hcc00, 24'h01_0000);
        check("continuous", {15'h0000, integrating}, 16'h0001);
        rd_chk("cont_result", 8'h00, 16'h5800);
        @(negedge ref_clk) light_level = 24'h00_0100;
        repeat (100) @(negedge ref_clk);
        rd_chk("latest", 8'h00, 16'h0100);
        u_lsr_host_model.write_word(8'h01, 16'hc800);
        check("abort", {15'h0000, integrating}, 16'h0000);
        u_lsr_host_model.write_word(8'h01, 16'hce00);
        check("restart", {15'h0000, integrating}, 16'h0001);
        u_lsr_host_model.write_word(8'h01, 16'hc800);
        check("host_acks", 16'(u_lsr_host_model.nak_seen), 16'h0000);
        $display("Test abort_restart done");
        results();
    end
endmodule
